/* design/itp_pkg.sv */
package itp_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int ITP_DATA_W = 8;
  localparam int ITP_COUNT_W = 16;
  localparam int ITP_NUM_CNT = 3;

  // ----------------------------------------------------------------
  // Port codes on the two port-select inputs
  // ----------------------------------------------------------------
  localparam logic [1:0] ITP_PORT_CNT0 = 2'h0;
  localparam logic [1:0] ITP_PORT_CNT1 = 2'h1;
  localparam logic [1:0] ITP_PORT_CNT2 = 2'h2;
  localparam logic [1:0] ITP_PORT_CTRL = 2'h3;

  // ----------------------------------------------------------------
  // Control word field positions (D7..D0)
  // ----------------------------------------------------------------
  localparam int ITP_PICK_LSB = 6;
  localparam int ITP_ORDER_LSB = 4;
  localparam int ITP_MODE_LSB = 1;
  localparam int ITP_BCD_BIT = 0;
  localparam logic [1:0] ITP_PICK_ILLEGAL = 2'h3;

  // ----------------------------------------------------------------
  // Reset values and the decimal wrap digit
  // ----------------------------------------------------------------
  localparam logic [7:0] ITP_CTRL_RST = 8'h00;
  localparam logic [15:0] ITP_COUNT_RST = 16'h0000;
  localparam logic [7:0] ITP_BYTE_RST = 8'h00;
  localparam logic [3:0] ITP_BCD_NINE = 4'h9;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ITP_ORD_LATCH = 2'b00,
    ITP_ORD_LSB = 2'b01,
    ITP_ORD_MSB = 2'b10,
    ITP_ORD_BOTH = 2'b11
  } itp_order_t;

  typedef enum logic {
    ITP_BYTE_LO = 1'b0,
    ITP_BYTE_HI = 1'b1
  } itp_byte_t;

  // Packed in the same bit order as the byte on the bus
  typedef struct packed {
    logic [1:0] counter_pick_field;
    itp_order_t byte_order_field;
    logic [2:0] mode;
    logic bcd;
  } itp_ctrl_t;

  // Host strobes and port select travel together through the sync
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic port_sel_hi;
    logic port_sel_lo;
  } itp_bus_t;

  localparam itp_bus_t ITP_BUS_IDLE = 5'h1C;

endpackage : itp_pkg

/* design/itp_channel.sv */
`timescale 1ns/1ns
module itp_channel (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Strobes from the host port
  input wire logic load_in,
  input wire logic ctrl_in,
  input wire logic read_done_in,
  input wire logic [7:0] byte_in,
  input wire itp_pkg::itp_ctrl_t cfg_in,
  // Count pulse
  input wire logic tick_in,
  // Results
  output logic [7:0] read_byte_out,
  output logic [15:0] count_out,
  output itp_pkg::itp_ctrl_t cfg_out
);
  import itp_pkg::*;

  itp_byte_t wr_ptr;
  itp_byte_t rd_ptr;
  logic [7:0] preset_lo;
  logic armed;
  logic latched;
  logic [15:0] latch_val;
  logic [15:0] src;
  logic load_done;
  logic [15:0] load_val;

  // Four-decade decrement, wrapping 0000 to 9999
  function automatic logic [15:0] bcd_dec(input logic [15:0] v);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    for (int d = 0; d < 4; d++) begin
      if (borrow) begin
        if (r[d*4 +: 4] == 4'h0) begin
          r[d*4 +: 4] = ITP_BCD_NINE;
        end else begin
          r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
          borrow = 1'b0;
        end
      end
    end
    return r;
  endfunction : bcd_dec

  // Which byte completes the preset, and the value it makes
  always_comb begin
    load_done = 1'b0;
    load_val = count_out;
    case (cfg_out.byte_order_field)
      ITP_ORD_LSB: begin
        load_done = load_in;
        load_val = {ITP_BYTE_RST, byte_in};
      end
      ITP_ORD_MSB: begin
        load_done = load_in;
        load_val = {byte_in, ITP_BYTE_RST};
      end
      ITP_ORD_BOTH: begin
        load_done = load_in & (wr_ptr == ITP_BYTE_HI);
        load_val = {byte_in, preset_lo};
      end
      default: begin
        load_done = 1'b0;
        load_val = count_out;
      end
    endcase
  end

  // Configuration held per counter; latch command leaves it alone
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      cfg_out <= ITP_CTRL_RST;
    end else if (ctrl_in && cfg_in.byte_order_field != ITP_ORD_LATCH) begin
      cfg_out <= cfg_in;
    end
  end

  // Preset loading and the down counter itself
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr <= ITP_BYTE_LO;
      preset_lo <= ITP_BYTE_RST;
      armed <= 1'b0;
      count_out <= ITP_COUNT_RST;
    end else if (ctrl_in && cfg_in.byte_order_field != ITP_ORD_LATCH) begin
      wr_ptr <= ITP_BYTE_LO;
      armed <= 1'b0;
    end else if (load_done) begin
      wr_ptr <= ITP_BYTE_LO;
      armed <= 1'b1;
      count_out <= load_val;
    end else if (load_in) begin
      // First of two bytes halts counting until the second lands
      wr_ptr <= ITP_BYTE_HI;
      preset_lo <= byte_in;
      armed <= 1'b0;
    end else if (tick_in && armed) begin
      count_out <= cfg_out.bcd ? bcd_dec(count_out)
                               : count_out - 16'h0001;
    end
  end

  // Snapshot for read back and the read byte pointer
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      latched <= 1'b0;
      latch_val <= ITP_COUNT_RST;
      rd_ptr <= ITP_BYTE_LO;
    end else if (ctrl_in && cfg_in.byte_order_field == ITP_ORD_LATCH) begin
      // A second latch before read out keeps the first snapshot
      if (!latched) begin
        latched <= 1'b1;
        latch_val <= count_out;
      end
    end else if (ctrl_in) begin
      latched <= 1'b0;
      rd_ptr <= ITP_BYTE_LO;
    end else if (read_done_in) begin
      if (cfg_out.byte_order_field == ITP_ORD_BOTH &&
          rd_ptr == ITP_BYTE_LO) begin
        rd_ptr <= ITP_BYTE_HI;
      end else begin
        rd_ptr <= ITP_BYTE_LO;
        latched <= 1'b0;
      end
    end
  end

  // Byte presented to the host
  assign src = latched ? latch_val : count_out;
  always_comb begin
    case (cfg_out.byte_order_field)
      ITP_ORD_MSB: read_byte_out = src[15:8];
      ITP_ORD_BOTH: read_byte_out = rd_ptr ? src[15:8] : src[7:0];
      default: read_byte_out = src[7:0];
    endcase
  end

endmodule : itp_channel

/* design/itp_host_port.sv */
`timescale 1ns/1ns
// Function
// - Three independent 16-bit counters share one host port.
// - Eight-bit data port is driven only during a selected read.
// - Strobes are ignored while device select is inactive.
// - Device select never affects counting.
// - Selected read places the addressed counter value on the bus.
// - Selected write takes mode or load data from the bus.
// - Port codes 0, 1, 2 address counters 0, 1, 2.
// - Code 3 write stores mode word; code 3 read is a no-op.
// - Mode control word cannot be read back.
// - Each counter is a presettable 16-bit down counter.
module itp_host_port #(
  parameter int NUM_CNT = itp_pkg::ITP_NUM_CNT,
  parameter int COUNT_W = itp_pkg::ITP_COUNT_W
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Host pins, asynchronous to mclk_in
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic port_sel_lo_in,
  input wire logic port_sel_hi_in,
  // Data pins split into input, output and enable
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n_out,
  // Count pulses from outside, asynchronous
  input wire logic [NUM_CNT-1:0] count_tick_in,
  // Counter core view
  output logic [NUM_CNT-1:0][COUNT_W-1:0] count_value_out,
  output itp_pkg::itp_ctrl_t [NUM_CNT-1:0] channel_cfg_out,
  output logic [NUM_CNT-1:0] load_strobe_out,
  output logic ctrl_strobe_out
);
  import itp_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  itp_bus_t bus_meta;
  itp_bus_t bus_sync;
  logic [7:0] data_meta;
  logic [7:0] data_sync;
  logic [NUM_CNT-1:0] tick_meta;
  logic [NUM_CNT-1:0] tick_sync;
  logic [NUM_CNT-1:0] tick_prev;
  logic [NUM_CNT-1:0] tick_pulse;

  logic [1:0] port_now;
  logic sel_rd;
  logic sel_wr;
  logic rd_counter;

  logic wr_active;
  logic [1:0] wr_port;
  logic [7:0] wr_data;
  logic wr_end;

  logic rd_active;
  logic [1:0] rd_port;
  logic rd_end;

  logic [NUM_CNT-1:0] load_pick;
  logic [NUM_CNT-1:0] ctrl_pick;
  logic [NUM_CNT-1:0] read_done;
  logic [NUM_CNT-1:0][7:0] read_byte;
  itp_ctrl_t ctrl_word;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------

  // Host strobes and select: two stages before any decode
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      bus_meta <= ITP_BUS_IDLE;
      bus_sync <= ITP_BUS_IDLE;
    end else begin
      bus_meta <= {cs_n_in, rd_n_in, wr_n_in,
                   port_sel_hi_in, port_sel_lo_in};
      bus_sync <= bus_meta;
    end
  end

  // Data bus: same depth as the strobes so both line up
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      data_meta <= ITP_BYTE_RST;
      data_sync <= ITP_BYTE_RST;
    end else begin
      data_meta <= data_in;
      data_sync <= data_meta;
    end
  end

  // Count pulses: edge found after the second stage only
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      tick_meta <= '0;
      tick_sync <= '0;
      tick_prev <= '0;
    end else begin
      tick_meta <= count_tick_in;
      tick_sync <= tick_meta;
      tick_prev <= tick_sync;
    end
  end

  // Rising edge of each count input; no select term on purpose
  assign tick_pulse = tick_sync & ~tick_prev;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------

  // Both strobes low at once is treated as no access at all
  assign port_now = {bus_sync.port_sel_hi, bus_sync.port_sel_lo};
  assign sel_rd = ~bus_sync.cs_n & ~bus_sync.rd_n & bus_sync.wr_n;
  assign sel_wr = ~bus_sync.cs_n & ~bus_sync.wr_n & bus_sync.rd_n;
  assign rd_counter = sel_rd & (port_now != ITP_PORT_CTRL);

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------

  // Track the byte while the strobe is low; the host guarantees
  // data setup before the trailing edge, so the last copy counts
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_active <= 1'b0;
      wr_port <= ITP_PORT_CNT0;
      wr_data <= ITP_BYTE_RST;
    end else begin
      wr_active <= sel_wr;
      if (sel_wr) begin
        wr_port <= port_now;
        wr_data <= data_sync;
      end
    end
  end

  // One pulse when the selected write ends
  assign wr_end = wr_active & ~sel_wr;
  assign ctrl_word = wr_data;

  // Load strobe per counter from the held port code
  always_comb begin
    for (int i = 0; i < NUM_CNT; i++) begin
      load_pick[i] = wr_end & (wr_port == i[1:0]);
    end
  end

  // Control word goes to the counter named in its pick field;
  // the illegal pick code reaches no counter
  always_comb begin
    for (int i = 0; i < NUM_CNT; i++) begin
      ctrl_pick[i] = wr_end & (wr_port == ITP_PORT_CTRL) &
                     (ctrl_word.counter_pick_field == i[1:0]);
    end
  end

  // Strobes shown to the core, one cycle each
  assign load_strobe_out = load_pick;
  assign ctrl_strobe_out = wr_end & (wr_port == ITP_PORT_CTRL);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Hold the port code of the read in progress so the byte
  // pointer advances on the counter that was actually read
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_active <= 1'b0;
      rd_port <= ITP_PORT_CNT0;
    end else begin
      rd_active <= rd_counter;
      if (rd_counter) begin
        rd_port <= port_now;
      end
    end
  end

  assign rd_end = rd_active & ~rd_counter;

  // End of read steps that counter's byte pointer
  always_comb begin
    for (int i = 0; i < NUM_CNT; i++) begin
      read_done[i] = rd_end & (rd_port == i[1:0]);
    end
  end

  // Output byte refreshed every cycle of a counter read; the
  // control word is never a source here
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      data_out <= ITP_BYTE_RST;
    end else if (rd_counter) begin
      case (port_now)
        ITP_PORT_CNT0: data_out <= read_byte[0];
        ITP_PORT_CNT1: data_out <= read_byte[1];
        ITP_PORT_CNT2: data_out <= read_byte[2];
        default: data_out <= data_out;
      endcase
    end
  end

  // Drive only once a valid byte is registered; low means driving
  assign data_oe_n_out = ~rd_active;

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------

  // Identical channels, none aware of the select pin
  for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
    itp_channel u_channel (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .load_in(load_pick[g]),
      .ctrl_in(ctrl_pick[g]),
      .read_done_in(read_done[g]),
      .byte_in(wr_data),
      .cfg_in(ctrl_word),
      .tick_in(tick_pulse[g]),
      .read_byte_out(read_byte[g]),
      .count_out(count_value_out[g]),
      .cfg_out(channel_cfg_out[g])
    );
  end

endmodule : itp_host_port

/* testbench/itp_host_port_monitor.sv */
`timescale 1ns/1ns
module itp_host_port_monitor #(
  parameter int NUM_CNT = 3,
  parameter int COUNT_W = 16
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Host pins
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic port_sel_lo_in,
  input wire logic port_sel_hi_in,
  input wire logic data_oe_n_out,
  // Core view
  input wire logic [NUM_CNT-1:0][COUNT_W-1:0] count_value_out,
  input wire itp_pkg::itp_ctrl_t [NUM_CNT-1:0] channel_cfg_out,
  input wire logic [NUM_CNT-1:0] load_strobe_out,
  input wire logic ctrl_strobe_out
);
  import itp_pkg::*;
  // ------------------------------------------------------------
  // Port timing checks, pins pass a two-flop sync
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // Port code as seen on the pins
  wire [1:0] code = {port_sel_hi_in, port_sel_lo_in};
  sequence s_read_start;
    (cs_n_in || rd_n_in) ##1
    (!cs_n_in && !rd_n_in && wr_n_in && code != ITP_PORT_CTRL)[*3];
  endsequence
  sequence s_write_end;
    (!cs_n_in && !wr_n_in && rd_n_in)[*3] ##1 (wr_n_in && !cs_n_in);
  endsequence
  property p_oe_read;
    !data_oe_n_out |-> !$past(rd_n_in, 3) && $past(wr_n_in, 3);
  endproperty
  a_oe_read: assert property (p_oe_read)
    else $error("bus driven without a read");
  property p_oe_sel;
    !data_oe_n_out |-> !$past(cs_n_in, 3);
  endproperty
  a_oe_sel: assert property (p_oe_sel)
    else $error("bus driven while deselected");
  property p_oe_code;
    !data_oe_n_out |-> $past(code, 3) != ITP_PORT_CTRL;
  endproperty
  a_oe_code: assert property (p_oe_code)
    else $error("control port read drove the bus");
  property p_read_drive;
    s_read_start |=> !data_oe_n_out;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("selected read did not drive the bus");
  property p_write_strobe;
    s_write_end |-> ##2 (ctrl_strobe_out || (|load_strobe_out));
  endproperty
  a_write_strobe: assert property (p_write_strobe)
    else $error("selected write gave no strobe");
  property p_load_port;
    (|load_strobe_out) |->
      load_strobe_out == (NUM_CNT'(1) << $past(code, 3));
  endproperty
  a_load_port: assert property (p_load_port)
    else $error("load strobe on wrong counter");
  property p_ctrl_port;
    ctrl_strobe_out |-> $past(code, 3) == ITP_PORT_CTRL;
  endproperty
  a_ctrl_port: assert property (p_ctrl_port)
    else $error("control strobe from wrong port");
  property p_strobe_pulse;
    (ctrl_strobe_out || (|load_strobe_out)) |=>
      !ctrl_strobe_out && load_strobe_out == '0;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("strobe longer than one cycle");
  // Binary counts only; decimal wrap is not modelled here
  property p_count_dec;
    $changed(count_value_out[0]) && !$past(load_strobe_out[0]) &&
      !$past(ctrl_strobe_out) && !channel_cfg_out[0].bcd |->
      count_value_out[0] == $past(count_value_out[0]) - 1'b1;
  endproperty
  a_count_dec: assert property (p_count_dec)
    else $error("count moved other than down by one");
endmodule : itp_host_port_monitor

bind itp_host_port itp_host_port_monitor #(
  .NUM_CNT(NUM_CNT),
  .COUNT_W(COUNT_W)
) u_mon (
  .mclk_in(mclk_in),
  .reset_in(reset_in),
  .cs_n_in(cs_n_in),
  .rd_n_in(rd_n_in),
  .wr_n_in(wr_n_in),
  .port_sel_lo_in(port_sel_lo_in),
  .port_sel_hi_in(port_sel_hi_in),
  .data_oe_n_out(data_oe_n_out),
  .count_value_out(count_value_out),
  .channel_cfg_out(channel_cfg_out),
  .load_strobe_out(load_strobe_out),
  .ctrl_strobe_out(ctrl_strobe_out)
);

/* testbench/itp_host_model.sv */
`timescale 1ns/1ns
module itp_host_model (
  // Clock
  input wire logic mclk_in,
  // Host pins toward the port
  output logic cs_n_out = 1'b1,
  output logic rd_n_out = 1'b1,
  output logic wr_n_out = 1'b1,
  output logic port_sel_lo_out = 1'b0,
  output logic port_sel_hi_out = 1'b0,
  // Data wire level and the port's drive
  output logic [7:0] data_out,
  input wire logic [7:0] dev_data_in,
  input wire logic dev_oe_n_in
);
  logic drv_en = 1'b0;
  logic [7:0] drv_data = 8'h00;
  logic [7:0] last = 8'h00;
  // Undriven wire shows the inverse of its last level, never a hold
  assign data_out = !dev_oe_n_in ? dev_data_in : drv_en ? drv_data : ~last;
  // Track the wire level for the floating case
  always @(posedge mclk_in) begin
    last <= data_out;
  end
  // One I/O cycle; strobe low for len cycles, pins held until then
  task automatic access(input logic sel_n, input logic wr,
    input logic [1:0] code, input logic [7:0] wdata, input int len,
    output logic [7:0] rdata, output logic drove);
    @(posedge mclk_in);
    cs_n_out <= sel_n;
    {port_sel_hi_out, port_sel_lo_out} <= code;
    drv_en <= wr;
    drv_data <= wdata;
    @(posedge mclk_in);
    if (wr) begin
      wr_n_out <= 1'b0;
    end else begin
      rd_n_out <= 1'b0;
    end
    repeat (len) @(posedge mclk_in);
    rdata = data_out;
    drove = !dev_oe_n_in;
    wr_n_out <= 1'b1;
    rd_n_out <= 1'b1;
    @(posedge mclk_in);
    cs_n_out <= 1'b1;
    drv_en <= 1'b0;
    repeat (4) @(posedge mclk_in);
  endtask : access
endmodule : itp_host_model

/* testbench/itp_host_port_tb.sv */
`timescale 1ns/1ns
module itp_host_port_tb;
  import itp_pkg::*;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [2:0] count_tick_in = 3'h0;
  logic cs_n, rd_n, wr_n, sel_lo, sel_hi, oe_n, cw, drove;
  logic [7:0] bus_in, bus_out, rd, w;
  logic [2:0][15:0] cnt;
  itp_ctrl_t [2:0] cfg;
  logic [2:0] ld;
  logic [15:0] v;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  // ------------------------------------------------------------
  // Design, host model and clock
  // ------------------------------------------------------------
  itp_host_port uut (.mclk_in(mclk_in), .reset_in(reset_in),
    .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .port_sel_lo_in(sel_lo), .port_sel_hi_in(sel_hi),
    .data_in(bus_in), .data_out(bus_out), .data_oe_n_out(oe_n),
    .count_tick_in(count_tick_in), .count_value_out(cnt),
    .channel_cfg_out(cfg), .load_strobe_out(ld), .ctrl_strobe_out(cw));
  itp_host_model host (.mclk_in(mclk_in), .cs_n_out(cs_n),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .port_sel_lo_out(sel_lo),
    .port_sel_hi_out(sel_hi), .data_out(bus_in),
    .dev_data_in(bus_out), .dev_oe_n_in(oe_n));
  // Free-running 25 MHz clock
  initial begin
    forever #20 mclk_in = ~mclk_in;
  end
  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
    input string what);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Selected write and read of one byte
  task automatic put(input logic [1:0] code, input logic [7:0] d);
    host.access(1'b0, 1'b1, code, d, 5, rd, drove);
  endtask : put
  task automatic get(input logic [1:0] code);
    host.access(1'b0, 1'b0, code, 8'h00, 5, rd, drove);
  endtask : get
  // Tick held long enough to cross the sync
  task automatic tick(input int i);
    count_tick_in[i] <= 1'b1;
    repeat (3) @(posedge mclk_in);
    count_tick_in[i] <= 1'b0;
    repeat (3) @(posedge mclk_in);
  endtask : tick
  // Main sequence
  initial begin
    repeat (8) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(posedge mclk_in);
    check(oe_n, 1'b1, "oe_n");
    check({ld, cw}, 16'h0000, "strobes");
    for (int i = 0; i < 3; i++) begin
      v = 16'h1234 + 16'(i) * 16'h1111;
      w = {2'(i), 2'b11, 3'b010, 1'b0};
      put(ITP_PORT_CTRL, w);
      check(cfg[i], w, "cfg");
      put(2'(i), v[7:0]);
      put(2'(i), v[15:8]);
      check(cnt[i], v, "count");
      get(2'(i));
      check(rd, v[7:0], "read lo");
      get(2'(i));
      check(rd, v[15:8], "read hi");
    end
    tick(0);
    tick(0);
    check(cnt[0], 16'h1232, "ticked");
    host.access(1'b1, 1'b1, 2'h0, 8'hEE, 7, rd, drove);
    check(cnt[0], 16'h1232, "deselected write");
    host.access(1'b1, 1'b0, 2'h0, 8'h00, 7, rd, drove);
    check(drove, 1'b0, "deselected read");
    host.access(1'b1, 1'b1, ITP_PORT_CTRL, 8'h10, 7, rd, drove);
    check(cfg[0], 8'h34, "deselected mode write");
    put(ITP_PORT_CTRL, 8'h00);
    tick(0);
    check(cnt[0], 16'h1231, "count after latch");
    get(2'h0);
    check(rd, 8'h32, "latched lo");
    get(2'h0);
    check(rd, 8'h12, "latched hi");
    get(2'h0);
    check(rd, 8'h31, "live lo");
    get(ITP_PORT_CTRL);
    check(drove, 1'b0, "control read");
    put(ITP_PORT_CTRL, 8'h90);
    put(2'h2, 8'hA5);
    check(cnt[2], 16'h00A5, "low only");
    get(2'h2);
    check(rd, 8'hA5, "low only read");
    put(ITP_PORT_CTRL, 8'h60);
    put(2'h1, 8'h5A);
    check(cnt[1], 16'h5A00, "high only");
    get(2'h1);
    check(rd, 8'h5A, "high only read");
    put(ITP_PORT_CTRL, 8'hF0);
    check(cfg[1], 8'h60, "cfg1 kept");
    check(cfg[2], 8'h90, "cfg2 kept");
    // Decimal counting: a loaded zero wraps to all nines
    put(ITP_PORT_CTRL, 8'h91);
    put(2'h2, 8'h00);
    tick(2);
    check(cnt[2], 16'h9999, "decimal wrap");
    get(2'h2);
    check(rd, 8'h99, "decimal read");
    print_verdict();
  end
endmodule : itp_host_port_tb
